// [design/hbpu_pkg.sv]
// hbpu_pkg: register map, field positions and mode codes of the breakpoint unit
package hbpu_pkg;
   // register indices; byte address on the bus is four times the index
   localparam logic [7:0] HBPU_IDX_CTRL0 = 8'h20;
   localparam logic [7:0] HBPU_IDX_CTRL1 = 8'h21;
   localparam logic [7:0] HBPU_IDX_ADDR_HI = 8'h22;
   localparam logic [7:0] HBPU_IDX_ADDR_LO = 8'h23;
   localparam logic [7:0] HBPU_IDX_DATA_HI = 8'h24;
   localparam logic [7:0] HBPU_IDX_DATA_LO = 8'h25;
   localparam logic [7:0] HBPU_IDX_STATUS = 8'h26;
   localparam int HBPU_IDX_SHIFT = 2;
   localparam int HBPU_AW = 10;
   // reset values
   localparam logic [7:0] HBPU_RST_BYTE = 8'h00;
   // control 0 fields
   localparam int HBPU_C0_MODE_HI = 7;
   localparam int HBPU_C0_MODE_LO = 6;
   localparam int HBPU_C0_PROG_ONLY = 5;
   localparam int HBPU_C0_SECOND_RANGE = 3;
   localparam int HBPU_C0_FIRST_RANGE = 2;
   localparam logic [7:0] HBPU_C0_WMASK = 8'hEC;
   // control 1 fields
   localparam int HBPU_C1_DATA_EN = 7;
   localparam int HBPU_C1_MASK_HI = 6;
   localparam int HBPU_C1_MASK_LO = 5;
   localparam int HBPU_C1_RW1_EN = 4;
   localparam int HBPU_C1_RW1_VAL = 3;
   localparam int HBPU_C1_RW0_EN = 2;
   localparam int HBPU_C1_RW0_VAL = 1;
   localparam int HBPU_C1_SIZE = 0;
   // status fields
   localparam int HBPU_ST_HIT0 = 0;
   localparam int HBPU_ST_HIT1 = 1;
   localparam int HBPU_ST_DBG_ACTIVE = 2;
   localparam int HBPU_ST_DBG_ENABLE = 3;
   // bus answers
   localparam logic [1:0] HBPU_RESP_OKAY = 2'h0;
   localparam logic [1:0] HBPU_RESP_SLVERR = 2'h2;
   // two-bit mode select
   typedef enum logic [1:0] {
      HBPU_MODE_OFF = 2'h0,
      HBPU_MODE_SWI_DUAL = 2'h1,
      HBPU_MODE_DBG_FULL = 2'h2,
      HBPU_MODE_DBG_DUAL = 2'h3
   } hbpu_mode_t;
endpackage : hbpu_pkg

// [design/hbpu_top.sv]
// hbpu_top: hardware breakpoint comparator with AXI4-Lite register access
//
// Decided for this implementation: the AXI4-Lite interface to the registers.
`timescale 1ns/1ns
// Functional notes
// - mode field: 00 off, 01 dual swi, 10 full debug, 11 dual debug
// - no match is reported while background debug state is active
// - only dual swi mode raises software interrupts; always fetch-tagged, no data breaks
// - dual swi mode ignores read/write compare bits of both breakpoints
// - in dual modes data compare enable enables the second address breakpoint
// - size select has no effect in dual modes
// - debug entry only while debug enable input is high
// - dual debug breakpoints qualified by program-only, range and own rw bits
// - program-only clear breaks at boundary; set tags executed opcodes only
// - program-only bit has no effect in dual swi mode
// - dual modes: second range bit adds low data byte to address compare
// - first range bit adds low address byte to compare in all modes
// - data compare enable clear keeps data compare bytes out of compares
// - full mode: mask high excludes data bits 15:8
// - full mode: mask low excludes data bits 7:0
// - second rw enable acts only on dual second breakpoint, not program breaks
// - a match forces debug entry or software interrupt per mode
// - control 0 read and write at any time
// - control 1 read and write in every mode
// - first rw enable set: value 0 matches writes, 1 matches reads
// - second rw enable set: value 0 matches writes, 1 matches reads
// - address compare high versus address msb, low versus lsb when enabled
module hbpu_top
   import hbpu_pkg::*;
(
   // clock and reset
   input wire logic aclk,
   input wire logic aresetn,
   // axi4-lite write address
   input wire logic [HBPU_AW-1:0] awaddr,
   input wire logic [2:0] awprot,
   input wire logic awvalid,
   output logic awready,
   // axi4-lite write data
   input wire logic [31:0] wdata,
   input wire logic [3:0] wstrb,
   input wire logic wvalid,
   output logic wready,
   // axi4-lite write response
   output logic [1:0] bresp,
   output logic bvalid,
   input wire logic bready,
   // axi4-lite read address
   input wire logic [HBPU_AW-1:0] araddr,
   input wire logic [2:0] arprot,
   input wire logic arvalid,
   output logic arready,
   // axi4-lite read data
   output logic [31:0] rdata,
   output logic [1:0] rresp,
   output logic rvalid,
   input wire logic rready,
   // cpu bus, same clock
   input wire logic [15:0] cpu_addr,
   input wire logic [15:0] cpu_data,
   input wire logic cpu_rw,
   input wire logic cpu_cycle,
   input wire logic cpu_fetch,
   // debug module status, same clock
   input wire logic background_debug_state,
   input wire logic debug_enable,
   // requests to cpu, one-cycle pulses
   output logic debug_break_now,
   output logic debug_break_tag,
   output logic software_interrupt_tag
);

   logic [7:0] ctrl0;
   logic [7:0] ctrl1;
   logic [7:0] addr_compare_high;
   logic [7:0] addr_compare_low;
   logic [7:0] data_compare_high;
   logic [7:0] data_compare_low;
   logic [HBPU_AW-1:0] wr_addr;
   logic [31:0] wr_data;
   logic [3:0] wr_strb;
   logic aw_held;
   logic w_held;
   logic wr_fire;
   logic [7:0] wr_idx;
   logic [7:0] rd_idx;
   logic [31:0] next_rdata;
   logic rd_hit;
   logic hit_first;
   logic hit_second;
   logic [1:0] last_hits;

   // field views of the control registers
   hbpu_mode_t mode;
   logic program_only_break;
   logic first_range_full;
   logic second_range_full;
   logic data_compare_enable;
   logic mask_high_byte;
   logic mask_low_byte;
   logic first_rw_compare_enable;
   logic first_rw_value;
   logic second_rw_compare_enable;
   logic second_rw_value;
   logic size_select;

   assign mode = hbpu_mode_t'({ctrl0[HBPU_C0_MODE_HI], ctrl0[HBPU_C0_MODE_LO]});
   assign program_only_break = ctrl0[HBPU_C0_PROG_ONLY];
   assign first_range_full = ctrl0[HBPU_C0_FIRST_RANGE];
   assign second_range_full = ctrl0[HBPU_C0_SECOND_RANGE];
   assign data_compare_enable = ctrl1[HBPU_C1_DATA_EN];
   assign mask_high_byte = ctrl1[HBPU_C1_MASK_HI];
   assign mask_low_byte = ctrl1[HBPU_C1_MASK_LO];
   assign second_rw_compare_enable = ctrl1[HBPU_C1_RW1_EN];
   assign second_rw_value = ctrl1[HBPU_C1_RW1_VAL];
   assign first_rw_compare_enable = ctrl1[HBPU_C1_RW0_EN];
   assign first_rw_value = ctrl1[HBPU_C1_RW0_VAL];
   assign size_select = ctrl1[HBPU_C1_SIZE];

   // write channel: address and data taken in either order, answer after both
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         awready <= 1'b0;
         wready <= 1'b0;
         aw_held <= 1'b0;
         w_held <= 1'b0;
         bvalid <= 1'b0;
         bresp <= HBPU_RESP_OKAY;
         wr_addr <= '0;
         wr_data <= '0;
         wr_strb <= '0;
      end else begin
         if (awvalid && awready) begin
            aw_held <= 1'b1;
            awready <= 1'b0;
            wr_addr <= awaddr;
         end else if (!aw_held && !bvalid) begin
            awready <= 1'b1;
         end
         if (wvalid && wready) begin
            w_held <= 1'b1;
            wready <= 1'b0;
            wr_data <= wdata;
            wr_strb <= wstrb;
         end else if (!w_held && !bvalid) begin
            wready <= 1'b1;
         end
         if (wr_fire) begin
            bvalid <= 1'b1;
            bresp <= (wr_addr[1:0] == 2'h0 && (wr_idx == HBPU_IDX_CTRL0
               || wr_idx == HBPU_IDX_CTRL1 || wr_idx == HBPU_IDX_ADDR_HI
               || wr_idx == HBPU_IDX_ADDR_LO || wr_idx == HBPU_IDX_DATA_HI
               || wr_idx == HBPU_IDX_DATA_LO || wr_idx == HBPU_IDX_STATUS))
               ? HBPU_RESP_OKAY : HBPU_RESP_SLVERR;
            aw_held <= 1'b0;
            w_held <= 1'b0;
         end else if (bvalid && bready) begin
            bvalid <= 1'b0;
         end
      end
   end

   assign wr_fire = aw_held && w_held && !bvalid;
   assign wr_idx = 8'(wr_addr[HBPU_AW-1:HBPU_IDX_SHIFT]);

   // register writes; only lane 0 carries the byte-wide registers
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         ctrl0 <= HBPU_RST_BYTE;
         ctrl1 <= HBPU_RST_BYTE;
         addr_compare_high <= HBPU_RST_BYTE;
         addr_compare_low <= HBPU_RST_BYTE;
         data_compare_high <= HBPU_RST_BYTE;
         data_compare_low <= HBPU_RST_BYTE;
      end else if (wr_fire && wr_strb[0] && wr_addr[1:0] == 2'h0) begin
         case (wr_idx)
            HBPU_IDX_CTRL0: ctrl0 <= wr_data[7:0] & HBPU_C0_WMASK;
            HBPU_IDX_CTRL1: ctrl1 <= wr_data[7:0];
            HBPU_IDX_ADDR_HI: addr_compare_high <= wr_data[7:0];
            HBPU_IDX_ADDR_LO: addr_compare_low <= wr_data[7:0];
            HBPU_IDX_DATA_HI: data_compare_high <= wr_data[7:0];
            HBPU_IDX_DATA_LO: data_compare_low <= wr_data[7:0];
            default: ;
         endcase
      end
   end

   // read mux; status is read-only and shows live debug inputs and last hits
   assign rd_idx = 8'(araddr[HBPU_AW-1:HBPU_IDX_SHIFT]);
   always_comb begin
      next_rdata = '0;
      rd_hit = (araddr[1:0] == 2'h0);
      case (rd_idx)
         HBPU_IDX_CTRL0: next_rdata[7:0] = ctrl0;
         HBPU_IDX_CTRL1: next_rdata[7:0] = ctrl1;
         HBPU_IDX_ADDR_HI: next_rdata[7:0] = addr_compare_high;
         HBPU_IDX_ADDR_LO: next_rdata[7:0] = addr_compare_low;
         HBPU_IDX_DATA_HI: next_rdata[7:0] = data_compare_high;
         HBPU_IDX_DATA_LO: next_rdata[7:0] = data_compare_low;
         HBPU_IDX_STATUS: begin
            next_rdata[HBPU_ST_HIT0] = last_hits[0];
            next_rdata[HBPU_ST_HIT1] = last_hits[1];
            next_rdata[HBPU_ST_DBG_ACTIVE] = background_debug_state;
            next_rdata[HBPU_ST_DBG_ENABLE] = debug_enable;
         end
         default: rd_hit = 1'b0;
      endcase
   end

   // read channel: answer one cycle after the address is taken
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         arready <= 1'b0;
         rvalid <= 1'b0;
         rdata <= '0;
         rresp <= HBPU_RESP_OKAY;
      end else if (arvalid && arready) begin
         arready <= 1'b0;
         rvalid <= 1'b1;
         rdata <= rd_hit ? next_rdata : '0;
         rresp <= rd_hit ? HBPU_RESP_OKAY : HBPU_RESP_SLVERR;
      end else if (rvalid && rready) begin
         rvalid <= 1'b0;
         arready <= 1'b1;
      end else if (!rvalid) begin
         arready <= 1'b1;
      end
   end

   // comparators; suppressed entirely while the debug rom runs
   always_comb begin
      logic addr_first;
      logic addr_second;
      logic data_ok;
      logic hi_ok;
      logic lo_ok;
      logic rw_first;
      logic rw_second;
      logic qual;
      // locals other than addr_first start cleared, addr_first is set at once, so no path can leave one undriven
      addr_second = 1'b0;
      data_ok = 1'b0;
      hi_ok = 1'b0;
      lo_ok = 1'b0;
      rw_first = 1'b0;
      rw_second = 1'b0;
      qual = 1'b0;
      addr_first = (cpu_addr[15:8] == addr_compare_high)
         && (!first_range_full || cpu_addr[7:0] == addr_compare_low);
      addr_second = data_compare_enable && (cpu_addr[15:8] == data_compare_high)
         && (!second_range_full || cpu_addr[7:0] == data_compare_low);
      hi_ok = mask_high_byte || cpu_data[15:8] == data_compare_high;
      lo_ok = mask_low_byte || cpu_data[7:0] == data_compare_low;
      // size select picks one lane by address parity, full mode only
      if (size_select) begin
         hi_ok = cpu_addr[0] || hi_ok;
         lo_ok = !cpu_addr[0] || lo_ok;
      end
      data_ok = !data_compare_enable || (hi_ok && lo_ok);
      rw_first = !first_rw_compare_enable || (cpu_rw == first_rw_value);
      rw_second = !second_rw_compare_enable || (cpu_rw == second_rw_value);
      qual = cpu_cycle && !background_debug_state;
      hit_first = 1'b0;
      hit_second = 1'b0;
      case (mode)
         HBPU_MODE_SWI_DUAL: begin
            // fetch only, rw and size ignored, program-only bit meaningless
            hit_first = qual && cpu_fetch && addr_first;
            hit_second = qual && cpu_fetch && addr_second;
         end
         HBPU_MODE_DBG_FULL: begin
            // tagged breaks skip the data and rw compares
            if (program_only_break) begin
               hit_first = qual && cpu_fetch && addr_first;
            end else begin
               hit_first = qual && addr_first && data_ok && rw_first;
            end
         end
         HBPU_MODE_DBG_DUAL: begin
            if (program_only_break) begin
               hit_first = qual && cpu_fetch && addr_first;
               hit_second = qual && cpu_fetch && addr_second;
            end else begin
               hit_first = qual && addr_first && rw_first;
               hit_second = qual && addr_second && rw_second;
            end
         end
         default: ;
      endcase
   end

   // one-cycle requests; debug entry gated by the debug enable input
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         debug_break_now <= 1'b0;
         debug_break_tag <= 1'b0;
         software_interrupt_tag <= 1'b0;
      end else begin
         software_interrupt_tag <= (mode == HBPU_MODE_SWI_DUAL)
            && (hit_first || hit_second);
         debug_break_tag <= mode[1] && program_only_break && debug_enable
            && (hit_first || hit_second);
         debug_break_now <= mode[1] && !program_only_break && debug_enable
            && (hit_first || hit_second);
      end
   end

   // last hit bits for the status register, refreshed each bus cycle
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         last_hits <= 2'h0;
      end else if (cpu_cycle) begin
         last_hits <= {hit_second, hit_first};
      end
   end

   // checks
   sequence s_wr_ctrl0;
      wr_fire && wr_strb[0] && wr_addr[1:0] == 2'h0 && wr_idx == HBPU_IDX_CTRL0;
   endsequence
   sequence s_full_data_hit;
      mode == HBPU_MODE_DBG_FULL && !program_only_break && cpu_cycle
         && !background_debug_state && debug_enable && data_compare_enable
         && mask_high_byte && mask_low_byte && !first_rw_compare_enable
         && cpu_addr[15:8] == addr_compare_high && !first_range_full;
   endsequence

   property p_off_quiet;
      @(posedge aclk) disable iff (!aresetn)
      mode == HBPU_MODE_OFF |=> !debug_break_now && !debug_break_tag
         && !software_interrupt_tag;
   endproperty
   a_off_quiet: assert property (p_off_quiet) else $error("request with mode off");

   property p_active_quiet;
      @(posedge aclk) disable iff (!aresetn)
      background_debug_state |=> !debug_break_now && !debug_break_tag
         && !software_interrupt_tag;
   endproperty
   a_active_quiet: assert property (p_active_quiet) else $error("break in debug");

   property p_swi_mode_only;
      @(posedge aclk) disable iff (!aresetn)
      software_interrupt_tag |-> $past(mode) == HBPU_MODE_SWI_DUAL && $past(cpu_fetch);
   endproperty
   a_swi_mode_only: assert property (p_swi_mode_only) else $error("swi bad mode");

   property p_debug_enabled;
      @(posedge aclk) disable iff (!aresetn)
      (debug_break_now || debug_break_tag) |-> $past(debug_enable) && $past(mode[1]);
   endproperty
   a_debug_enabled: assert property (p_debug_enabled) else $error("debug without enable");

   property p_prog_only_fetch;
      @(posedge aclk) disable iff (!aresetn)
      program_only_break && !cpu_fetch |=> !debug_break_tag && !debug_break_now
         && !software_interrupt_tag;
   endproperty
   a_prog_only_fetch: assert property (p_prog_only_fetch) else $error("non-fetch break");

   property p_masked_data_hits;
      @(posedge aclk) disable iff (!aresetn)
      s_full_data_hit |=> debug_break_now;
   endproperty
   a_masked_data_hits: assert property (p_masked_data_hits) else $error("masked miss");

   property p_data_off_no_second;
      @(posedge aclk) disable iff (!aresetn)
      mode[0] && !data_compare_enable && cpu_addr[15:8] != addr_compare_high
         |=> !debug_break_now && !debug_break_tag && !software_interrupt_tag;
   endproperty
   a_data_off_no_second: assert property (p_data_off_no_second) else $error("second live");

   property p_ctrl0_write;
      @(posedge aclk) disable iff (!aresetn)
      s_wr_ctrl0 |=> ctrl0 == ($past(wr_data[7:0]) & HBPU_C0_WMASK) && bvalid;
   endproperty
   a_ctrl0_write: assert property (p_ctrl0_write) else $error("ctrl0 write lost");

   property p_reset_off;
      @(posedge aclk) !aresetn |=> ctrl0 == HBPU_RST_BYTE && ctrl1 == HBPU_RST_BYTE;
   endproperty
   a_reset_off: assert property (p_reset_off) else $error("control not cleared");

   property p_resp_hold;
      @(posedge aclk) disable iff (!aresetn)
      bvalid && !bready |=> bvalid && $stable(bresp);
   endproperty
   a_resp_hold: assert property (p_resp_hold) else $error("bresp dropped");

endmodule : hbpu_top

// [dv/hbpu_cpu_model.sv]
// hbpu_cpu_model: behavioural cpu bus that feeds the breakpoint comparator
`timescale 1ns/1ns
module hbpu_cpu_model (
   // clock
   input wire logic aclk,
   // cpu bus
   output logic [15:0] cpu_addr,
   output logic [15:0] cpu_data,
   output logic cpu_rw,
   output logic cpu_cycle,
   output logic cpu_fetch
);
   // idle bus at time zero
   initial begin
      cpu_addr = 16'h0000;
      cpu_data = 16'h0000;
      cpu_rw = 1'h1;
      cpu_cycle = 1'h0;
      cpu_fetch = 1'h0;
   end

   // one access after gap idle cycles; idle lines show the inverse so stale values never match
   task automatic bus_cycle(input logic [15:0] a, input logic [15:0] d, input logic rw,
         input logic f, input int gap);
      repeat (gap) @(posedge aclk);
      @(posedge aclk);
      cpu_addr <= a;
      cpu_data <= d;
      cpu_rw <= rw;
      cpu_fetch <= f;
      cpu_cycle <= 1'h1;
      @(posedge aclk);
      cpu_cycle <= 1'h0;
      cpu_fetch <= 1'h0;
      cpu_addr <= ~a;
      cpu_data <= ~d;
      cpu_rw <= ~rw;
   endtask : bus_cycle
endmodule : hbpu_cpu_model

// [dv/hbpu_top_test.sv]
// hbpu_top_test: register and breakpoint match checks for the breakpoint unit
`timescale 1ns/1ns
module hbpu_top_test;
   import hbpu_pkg::*;
   typedef struct packed {
      logic [7:0] c0;
      logic [7:0] c1;
      logic [15:0] a;
      logic [15:0] d;
      logic rw;
      logic f;
      logic bds;
      logic den;
      logic [2:0] exp;
   } hbpu_case_t;
   localparam int NROWS = 29;
   // expected request vector is {break_now, break_tag, swi_tag}
   hbpu_case_t rows [0:NROWS-1] = '{
      '{8'h00, 8'h00, 16'h1234, 16'h0000, 1'h1, 1'h0, 1'h0, 1'h1, 3'h0},
      '{8'h84, 8'h00, 16'h1234, 16'h0000, 1'h1, 1'h0, 1'h0, 1'h1, 3'h4},
      '{8'h84, 8'h00, 16'h1235, 16'h0000, 1'h1, 1'h0, 1'h0, 1'h1, 3'h0},
      '{8'h80, 8'h00, 16'h1235, 16'h0000, 1'h1, 1'h0, 1'h0, 1'h1, 3'h4},
      '{8'h80, 8'h00, 16'h1334, 16'h0000, 1'h1, 1'h0, 1'h0, 1'h1, 3'h0},
      '{8'h84, 8'h80, 16'h1234, 16'hABCD, 1'h1, 1'h0, 1'h0, 1'h1, 3'h4},
      '{8'h84, 8'h80, 16'h1234, 16'hABCE, 1'h1, 1'h0, 1'h0, 1'h1, 3'h0},
      '{8'h84, 8'hA0, 16'h1234, 16'hABCE, 1'h1, 1'h0, 1'h0, 1'h1, 3'h4},
      '{8'h84, 8'hC0, 16'h1234, 16'h00CD, 1'h1, 1'h0, 1'h0, 1'h1, 3'h4},
      '{8'h84, 8'hC0, 16'h1234, 16'h00CE, 1'h1, 1'h0, 1'h0, 1'h1, 3'h0},
      '{8'h84, 8'h06, 16'h1234, 16'h0000, 1'h1, 1'h0, 1'h0, 1'h1, 3'h4},
      '{8'h84, 8'h06, 16'h1234, 16'h0000, 1'h0, 1'h0, 1'h0, 1'h1, 3'h0},
      '{8'h84, 8'h04, 16'h1234, 16'h0000, 1'h0, 1'h0, 1'h0, 1'h1, 3'h4},
      '{8'h84, 8'h00, 16'h1234, 16'h0000, 1'h1, 1'h0, 1'h1, 1'h1, 3'h0},
      '{8'h84, 8'h00, 16'h1234, 16'h0000, 1'h1, 1'h0, 1'h0, 1'h0, 3'h0},
      '{8'h80, 8'hE0, 16'h1299, 16'h5555, 1'h1, 1'h0, 1'h0, 1'h1, 3'h4},
      '{8'h84, 8'h81, 16'h1234, 16'hAB00, 1'h1, 1'h0, 1'h0, 1'h1, 3'h4},
      '{8'hA4, 8'h00, 16'h1234, 16'h0000, 1'h1, 1'h1, 1'h0, 1'h1, 3'h2},
      '{8'hA4, 8'h00, 16'h1234, 16'h0000, 1'h1, 1'h0, 1'h0, 1'h1, 3'h0},
      '{8'hA4, 8'h86, 16'h1234, 16'h0000, 1'h0, 1'h1, 1'h0, 1'h1, 3'h2},
      '{8'hCC, 8'h80, 16'hABCD, 16'h0000, 1'h1, 1'h0, 1'h0, 1'h1, 3'h4},
      '{8'hCC, 8'h00, 16'hABCD, 16'h0000, 1'h1, 1'h0, 1'h0, 1'h1, 3'h0},
      '{8'hC4, 8'h80, 16'hABEE, 16'h0000, 1'h1, 1'h0, 1'h0, 1'h1, 3'h4},
      '{8'hCC, 8'h80, 16'hABEE, 16'h0000, 1'h1, 1'h0, 1'h0, 1'h1, 3'h0},
      '{8'hCC, 8'h90, 16'hABCD, 16'h0000, 1'h1, 1'h0, 1'h0, 1'h1, 3'h0},
      '{8'hCC, 8'h90, 16'hABCD, 16'h0000, 1'h0, 1'h0, 1'h0, 1'h1, 3'h4},
      '{8'hCD, 8'h85, 16'h1234, 16'h0000, 1'h1, 1'h0, 1'h0, 1'h1, 3'h0},
      '{8'hEC, 8'h04, 16'h1234, 16'h0000, 1'h1, 1'h1, 1'h0, 1'h1, 3'h2},
      '{8'h6C, 8'h97, 16'hABCD, 16'h0000, 1'h1, 1'h1, 1'h0, 1'h0, 3'h1}
   };
   logic aclk = 1'h0;
   logic aresetn = 1'h0;
   logic [HBPU_AW-1:0] awaddr = 10'h000;
   logic awvalid = 1'h0;
   logic [31:0] wdata = 32'h0;
   logic [3:0] wstrb = 4'hF;
   logic wvalid = 1'h0;
   logic bready = 1'h0;
   logic [HBPU_AW-1:0] araddr = 10'h000;
   logic arvalid = 1'h0;
   logic rready = 1'h0;
   logic background_debug_state = 1'h0;
   logic debug_enable = 1'h0;
   logic awready, wready, bvalid, arready, rvalid, cpu_rw, cpu_cycle, cpu_fetch;
   logic [1:0] bresp, rresp, rs;
   logic [31:0] rdata, rd;
   logic [15:0] cpu_addr, cpu_data;
   logic debug_break_now, debug_break_tag, software_interrupt_tag;
   int failures = 0;
   int checked = 0;

   // 50 MHz clock
   always #10 aclk = ~aclk;

   hbpu_top i_hbpu_top (.aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awprot(3'h0),
      .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid),
      .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr),
      .arprot(3'h0), .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp),
      .rvalid(rvalid), .rready(rready), .cpu_addr(cpu_addr), .cpu_data(cpu_data),
      .cpu_rw(cpu_rw), .cpu_cycle(cpu_cycle), .cpu_fetch(cpu_fetch),
      .background_debug_state(background_debug_state), .debug_enable(debug_enable),
      .debug_break_now(debug_break_now), .debug_break_tag(debug_break_tag),
      .software_interrupt_tag(software_interrupt_tag));

   hbpu_cpu_model i_hbpu_cpu_model (.aclk(aclk), .cpu_addr(cpu_addr), .cpu_data(cpu_data),
      .cpu_rw(cpu_rw), .cpu_cycle(cpu_cycle), .cpu_fetch(cpu_fetch));

   // write and read hold each channel until its own ready; entered just after an edge
   task automatic axi_write(input logic [7:0] idx, input logic [31:0] d, output logic [1:0] r);
      int n;
      n = 0;
      awaddr <= {idx, 2'h0};
      wdata <= d;
      awvalid <= 1'h1;
      wvalid <= 1'h1;
      bready <= 1'h1;
      do begin
         @(posedge aclk);
         n++;
         if (awready === 1'h1) awvalid <= 1'h0;
         if (wready === 1'h1) wvalid <= 1'h0;
      end while (bvalid !== 1'h1 && n < 100);
      r = bresp;
      bready <= 1'h0;
      if (n >= 100) failures++;
      // let an edge pass so a following call never re-drives bready in this step
      @(posedge aclk);
   endtask : axi_write

   task automatic axi_read(input logic [7:0] idx, output logic [31:0] d, output logic [1:0] r);
      int n;
      n = 0;
      araddr <= {idx, 2'h0};
      arvalid <= 1'h1;
      rready <= 1'h1;
      do begin
         @(posedge aclk);
         n++;
         if (arready === 1'h1) arvalid <= 1'h0;
      end while (rvalid !== 1'h1 && n < 100);
      d = rdata;
      r = rresp;
      rready <= 1'h0;
      if (n >= 100) failures++;
      @(posedge aclk);
   endtask : axi_read

   task automatic chk_reg(input logic [31:0] got, input logic [31:0] exp);
      checked++;
      if (got !== exp) begin
         failures++;
         $display("wrong value at %0t: register got %h expected %h", $time, got, exp);
      end
   endtask : chk_reg

   task automatic chk_req(input logic [2:0] got, input logic [2:0] exp);
      checked++;
      if (got !== exp) begin
         failures++;
         $display("wrong value at %0t: requests got %b expected %b", $time, got, exp);
      end
   endtask : chk_req

   task automatic finish_test;
      $display("comparisons %0d failures %0d", checked, failures);
      if (failures == 0 && checked > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask : finish_test

   // watchdog: the whole sequence needs about six hundred cycles
   initial begin
      repeat (6000) @(posedge aclk);
      failures++;
      finish_test();
   end

   // main sequence
   initial begin
      repeat (6) @(posedge aclk);
      aresetn <= 1'h1;
      @(posedge aclk);
      for (int i = 0; i < 6; i++) begin
         axi_read(HBPU_IDX_CTRL0 + 8'(i), rd, rs);
         chk_reg(rd, 32'h0);
      end
      axi_read(8'h30, rd, rs);
      chk_reg({30'h0, rs}, {30'h0, HBPU_RESP_SLVERR});
      axi_write(8'h30, 32'hFF, rs);
      chk_reg({30'h0, rs}, {30'h0, HBPU_RESP_SLVERR});
      axi_write(HBPU_IDX_ADDR_HI, 32'h12, rs);
      axi_write(HBPU_IDX_ADDR_LO, 32'h34, rs);
      axi_write(HBPU_IDX_DATA_HI, 32'hAB, rs);
      axi_write(HBPU_IDX_DATA_LO, 32'hCD, rs);
      axi_read(HBPU_IDX_DATA_LO, rd, rs);
      chk_reg(rd, 32'hCD);
      // each row: program both controls, read them back, run one bus access
      for (int i = 0; i < NROWS; i++) begin
         axi_write(HBPU_IDX_CTRL0, {24'h0, rows[i].c0}, rs);
         axi_write(HBPU_IDX_CTRL1, {24'h0, rows[i].c1}, rs);
         axi_read(HBPU_IDX_CTRL0, rd, rs);
         chk_reg(rd, {24'h0, rows[i].c0 & HBPU_C0_WMASK});
         axi_read(HBPU_IDX_CTRL1, rd, rs);
         chk_reg(rd, {24'h0, rows[i].c1});
         background_debug_state <= rows[i].bds;
         debug_enable <= rows[i].den;
         i_hbpu_cpu_model.bus_cycle(rows[i].a, rows[i].d, rows[i].rw, rows[i].f, i % 3);
         #1;
         chk_req({debug_break_now, debug_break_tag, software_interrupt_tag}, rows[i].exp);
         @(posedge aclk);
         #1;
         chk_req({debug_break_now, debug_break_tag, software_interrupt_tag}, 3'h0);
         @(posedge aclk);
      end
      finish_test();
   end
endmodule : hbpu_top_test
